/* File: dv/apd_config_decode_checker.sv */
`timescale 1ns/1ps
module apd_config_decode_checker (
	input wire logic ref_clk, // clock
	input wire logic rst_n, // sync reset, active low
	input wire logic [7:0] reg_addr, // register address
	input wire logic [7:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	input wire logic [7:0] reg_rdata, // read data
	input wire logic sleep_req, // sleep level
	input wire logic general_pin_one, // bias pin
	input wire apd_pkg::apd_chan_type out_ch1, // channel 1
	input wire apd_pkg::apd_chan_type out_ch2, // channel 2
	input wire apd_pkg::apd_ref_type reference_ctrl, // reference
	input wire apd_pkg::apd_bias_type mic_bias_ctrl // bias
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	chk_rsv_src_off: assert property (out_ch1.reserved_code |-> out_ch1.route == 5'h00)
		else $error("ch1 routed on reserved code");
	chk_ch2_rsv_off: assert property (out_ch2.reserved_code |-> out_ch2.route == 5'h00 && out_ch2.pins == 6'h00)
		else $error("ch2 routed on reserved code");
	chk_diff_pair: assert property (out_ch1.pins.differential |-> out_ch1.pins[5:4] == 2'h3 && out_ch1.pins[2:0] == 3'h0)
		else $error("ch1 differential pins wrong");
	chk_sense_neg_cm: assert property (out_ch1.pins.cm_sense_remote |-> out_ch1.pins.neg_common_mode && out_ch1.pins.pos_active)
		else $error("remote sense without neg common mode");
	chk_ch2_diff: assert property (out_ch2.pins.differential |-> !out_ch2.pins.pos_common_mode && !out_ch2.pins.neg_common_mode)
		else $error("ch2 differential with common mode");
	chk_ref_onehot: assert property ($onehot0(reference_ctrl.level_onehot))
		else $error("reference level not one-hot");
	chk_wake_charge: assert property ($fell(sleep_req) |-> ##[1:3] reference_ctrl.fast_charge && reference_ctrl.power_on)
		else $error("no fast charge after wake");
	chk_settle_after: assert property ($rose(reference_ctrl.settled) |-> $past(reference_ctrl.fast_charge))
		else $error("settled without charge");
	chk_sleep_off: assert property (sleep_req [*3] |-> !reference_ctrl.power_on && !reference_ctrl.settled)
		else $error("reference powered in sleep");
	chk_bias_one_src: assert property ($onehot0(mic_bias_ctrl[3:1]))
		else $error("several bias sources");
	chk_half_ref: assert property (mic_bias_ctrl.half_ref |-> reference_ctrl.level_onehot[1:0] != 2'h0)
		else $error("half bias on reserved reference");
	chk_bias_power: assert property (mic_bias_ctrl.power_on |-> mic_bias_ctrl[3:1] != 3'h0)
		else $error("bias powered without level");
	chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read slot");
endmodule // apd_config_decode_checker
bind apd_config_decode apd_config_decode_checker chk_i (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_req(sleep_req),
	.general_pin_one(general_pin_one), .out_ch1(out_ch1), .out_ch2(out_ch2), .reference_ctrl(reference_ctrl),
	.mic_bias_ctrl(mic_bias_ctrl));

/* File: dv/test_apd_config_decode.sv */
`timescale 1ns/1ps
module test_apd_config_decode;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic sleep_req = 1'b0;
	logic general_pin_one = 1'b0;
	apd_pkg::apd_chan_type out_ch1;
	apd_pkg::apd_chan_type out_ch2;
	apd_pkg::apd_ref_type reference_ctrl;
	apd_pkg::apd_bias_type mic_bias_ctrl;
	int err_count = 0;
	int compares = 0;
	int n;
	logic [7:0] d;
	localparam int QC[4] = '{5, 10, 20, 40};
	localparam int RT[8] = '{0, 26, 21, 31, 25, 22, 0, 0};
	localparam int PV[8] = '{56, 48, 32, 16, 34, 35, 20, 0};
	localparam int PM[8] = '{63, 63, 63, 63, 39, 39, 23, 63};
	localparam int BB[6] = '{0, 0, 1, 3, 2, 1};
	localparam int RR[6] = '{0, 3, 1, 2, 0, 2};
	localparam int LV[6] = '{1, 0, 2, 4, 1, 4};
	localparam int BX[6] = '{9, 0, 5, 3, 0, 0};
	// short charge counts keep the wake sequence to tens of cycles
	apd_config_decode #(.QCHG_CYC_0(5), .QCHG_CYC_1(10), .QCHG_CYC_2(20), .QCHG_CYC_3(40)) uut (
		.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_req(sleep_req), .general_pin_one(general_pin_one),
		.out_ch1(out_ch1), .out_ch2(out_ch2), .reference_ctrl(reference_ctrl), .mic_bias_ctrl(mic_bias_ctrl));
	initial begin
		forever #2 ref_clk = ~ref_clk;
	end
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	// decoded outputs lag the write edge by one cycle
	task automatic settle;
		@(posedge ref_clk);
		#1;
	endtask
	task automatic complete_run;
		if (err_count == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		#100000;
		err_count++;
		complete_run();
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		settle();
		chk("rst_route", 8'h00, 8'(out_ch1.route));
		chk("rst_pins", 8'h38, 8'(out_ch1.pins));
		chk("rst_level", 8'h01, 8'(reference_ctrl.level_onehot));
		chk("rst_bias", 8'h08, 8'(mic_bias_ctrl));
		rd(apd_pkg::ADDR_REF_CHARGE, d);
		chk("rst_qchg", 8'h00, d);
		for (int i = 0; i < 8; i++) begin
			wr(apd_pkg::ADDR_CH1_CFG, {i[2:0], 5'h00});
			wr(apd_pkg::ADDR_CH2_CFG, {i[2:0], 5'h00});
			settle();
			chk("src1", 8'(RT[i]), 8'(out_ch1.route));
			chk("src2", 8'(RT[i]), 8'(out_ch2.route));
			chk("rsv_src", 8'(i >= 6), 8'(out_ch1.reserved_code));
			chk("rsv_src2", 8'(i >= 6), 8'(out_ch2.reserved_code));
		end
		for (int i = 0; i < 8; i++) begin
			wr(apd_pkg::ADDR_CH1_CFG, {3'h1, i[2:0], 2'h0});
			wr(apd_pkg::ADDR_CH2_CFG, {3'h1, i[2:0], 2'h0});
			settle();
			chk("mode1", 8'(PV[i]), 8'(out_ch1.pins & 6'(PM[i])));
			chk("mode2", 8'(PV[i]), 8'(out_ch2.pins & 6'(PM[i])));
			chk("rsv_mode", 8'(i == 7), 8'(out_ch1.reserved_code));
		end
		rd(apd_pkg::ADDR_CH1_CFG, d);
		chk("readback", 8'h3C, d);
		wr(apd_pkg::ADDR_DRIVE, 8'hE4);
		settle();
		chk("drive", 8'hE4, {out_ch1.pos_drive, out_ch1.neg_drive, out_ch2.pos_drive, out_ch2.neg_drive});
		wr(8'h10, 8'hFF);
		rd(8'h10, d);
		chk("unmapped", 8'h00, d);
		for (int j = 0; j < 4; j++) begin
			wr(apd_pkg::ADDR_MISC, {6'h00, j[1:0]});
			settle();
			chk("swing", {6'h00, j[1:0]}, {6'h00, out_ch2.double_swing, out_ch1.double_swing});
		end
		wr(apd_pkg::ADDR_BIAS_PWR, 8'h20);
		for (int i = 0; i < 6; i++) begin
			wr(apd_pkg::ADDR_LEVELS, 8'(BB[i] * 4 + RR[i]));
			settle();
			chk("level", 8'(LV[i]), 8'(reference_ctrl.level_onehot));
			chk("bias", 8'(BX[i]), 8'(mic_bias_ctrl));
		end
		wr(apd_pkg::ADDR_LEVELS, 8'h00);
		wr(apd_pkg::ADDR_BIAS_PWR, 8'h00);
		settle();
		chk("bias_off", 8'h08, 8'(mic_bias_ctrl));
		wr(apd_pkg::ADDR_MISC, 8'h04);
		wr(apd_pkg::ADDR_BIAS_PWR, 8'h20);
		repeat (6) settle();
		chk("pin_low", 8'h00, 8'(mic_bias_ctrl.power_on));
		@(posedge ref_clk);
		general_pin_one <= 1'b1;
		wr(apd_pkg::ADDR_BIAS_PWR, 8'h00);
		repeat (6) settle();
		chk("pin_high", 8'h01, 8'(mic_bias_ctrl.power_on));
		for (int q = 0; q < 4; q++) begin
			wr(apd_pkg::ADDR_REF_CHARGE, 8'(q * 8));
			@(posedge ref_clk);
			sleep_req <= 1'b1;
			repeat (4) settle();
			chk("asleep", 8'h00, {6'h00, reference_ctrl.power_on, reference_ctrl.settled});
			@(posedge ref_clk);
			sleep_req <= 1'b0;
			n = 0;
			while (reference_ctrl.settled !== 1'b1 && n < 100) begin
				settle();
				n++;
				if (n == 3) begin
					chk("charging", 8'h01, 8'(reference_ctrl.fast_charge));
				end
			end
			chk("charge_len", 8'h01, 8'(n >= QC[q] + 1 && n <= QC[q] + 3));
		end
		// settled, pin high with pin control, both channels parked on reserved pin modes
		rd(apd_pkg::ADDR_STATUS, d);
		chk("status", 8'h6D, d);
		complete_run();
	end
endmodule // test_apd_config_decode

/* File: shared/apd_pkg.sv */
package apd_pkg;

	// register port
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	localparam logic [7:0] ADDR_REF_CHARGE = 8'h02;
	localparam logic [7:0] ADDR_LEVELS = 8'h4D;
	localparam logic [7:0] ADDR_CH1_CFG = 8'h64;
	localparam logic [7:0] ADDR_DRIVE = 8'h65;
	localparam logic [7:0] ADDR_CH2_CFG = 8'h6B;
	localparam logic [7:0] ADDR_BIAS_PWR = 8'h78;
	localparam logic [7:0] ADDR_MISC = 8'h79;
	localparam logic [7:0] ADDR_STATUS = 8'h7A;

	// field positions
	localparam int SRC_MSB = 7;
	localparam int SRC_LSB = 5;
	localparam int MODE_MSB = 4;
	localparam int MODE_LSB = 2;
	localparam int QCHG_MSB = 4;
	localparam int QCHG_LSB = 3;
	localparam int BIAS_MSB = 3;
	localparam int BIAS_LSB = 2;
	localparam int REF_MSB = 1;
	localparam int REF_LSB = 0;
	localparam int BIAS_PWR_BIT = 5;
	localparam int DRV_C1P_MSB = 7;
	localparam int DRV_C1P_LSB = 6;
	localparam int DRV_C1N_MSB = 5;
	localparam int DRV_C1N_LSB = 4;
	localparam int DRV_C2P_MSB = 3;
	localparam int DRV_C2P_LSB = 2;
	localparam int DRV_C2N_MSB = 1;
	localparam int DRV_C2N_LSB = 0;
	localparam int MISC_SWING1_BIT = 0;
	localparam int MISC_SWING2_BIT = 1;
	localparam int MISC_PIN_BIAS_BIT = 2;

	// reset values
	localparam logic [7:0] RST_REG = 8'h00;

	// source codes
	localparam logic [2:0] SRC_OFF = 3'h0;
	localparam logic [2:0] SRC_DAC = 3'h1;
	localparam logic [2:0] SRC_BYPASS = 3'h2;
	localparam logic [2:0] SRC_MIX = 3'h3;
	localparam logic [2:0] SRC_PDAC_NBYP = 3'h4;
	localparam logic [2:0] SRC_PBYP_NDAC = 3'h5;

	// pin mode codes
	localparam logic [2:0] MODE_DIFF = 3'h0;
	localparam logic [2:0] MODE_SE_PAIR = 3'h1;
	localparam logic [2:0] MODE_SE_POS = 3'h2;
	localparam logic [2:0] MODE_SE_NEG = 3'h3;
	localparam logic [2:0] MODE_PD_POS = 3'h4;
	localparam logic [2:0] MODE_PD_POS_SENSE = 3'h5;
	localparam logic [2:0] MODE_PD_NEG = 3'h6;

	// reference and bias codes
	localparam logic [1:0] REF_2V75 = 2'h0;
	localparam logic [1:0] REF_2V5 = 2'h1;
	localparam logic [1:0] REF_1V375 = 2'h2;
	localparam logic [1:0] BIAS_AS_REF = 2'h0;
	localparam logic [1:0] BIAS_HALF_REF = 2'h1;
	localparam logic [1:0] BIAS_SUPPLY = 2'h3;

	// fast-charge durations
	localparam int CLK_MHZ = 250;
	localparam int QCHG_US_0 = 3500;
	localparam int QCHG_US_1 = 10000;
	localparam int QCHG_US_2 = 50000;
	localparam int QCHG_US_3 = 100000;
	localparam int QCHG_CYC_0 = QCHG_US_0 * CLK_MHZ;
	localparam int QCHG_CYC_1 = QCHG_US_1 * CLK_MHZ;
	localparam int QCHG_CYC_2 = QCHG_US_2 * CLK_MHZ;
	localparam int QCHG_CYC_3 = QCHG_US_3 * CLK_MHZ;
	localparam int QCHG_CNT_W = 25;

	typedef struct packed {
		logic driver_en;
		logic pos_dac;
		logic pos_bypass;
		logic neg_dac;
		logic neg_bypass;
	} apd_route_type;

	typedef struct packed {
		logic pos_active;
		logic neg_active;
		logic differential;
		logic pos_common_mode;
		logic neg_common_mode;
		logic cm_sense_remote;
	} apd_pin_type;

	typedef struct packed {
		apd_route_type route;
		apd_pin_type pins;
		logic [1:0] pos_drive;
		logic [1:0] neg_drive;
		logic double_swing;
		logic reserved_code;
	} apd_chan_type;

	typedef struct packed {
		logic [2:0] level_onehot;
		logic power_on;
		logic fast_charge;
		logic settled;
	} apd_ref_type;

	typedef struct packed {
		logic from_ref;
		logic half_ref;
		logic from_supply;
		logic power_on;
	} apd_bias_type;

	typedef enum logic [1:0] {
		REF_ST_OFF = 2'b00,
		REF_ST_CHARGE = 2'b01,
		REF_ST_SETTLED = 2'b10
	} apd_ref_state_type;

endpackage

/* File: verilog/apd_chan_decode.sv */
`timescale 1ns/1ps
module apd_chan_decode (
	input wire logic [2:0] source_sel, // source field
	input wire logic [2:0] pin_mode, // pin mode field
	output apd_pkg::apd_route_type route, // decoded routing
	output apd_pkg::apd_pin_type pins, // decoded pin use
	output logic reserved_code // reserved code seen
);
	logic src_bad;
	logic mode_bad;

	always_comb begin
		route = '0;
		src_bad = 1'b0;
		case (source_sel)
			apd_pkg::SRC_OFF: route = '0;
			apd_pkg::SRC_DAC: route = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
			apd_pkg::SRC_BYPASS: route = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
			apd_pkg::SRC_MIX: route = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
			apd_pkg::SRC_PDAC_NBYP: route = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
			apd_pkg::SRC_PBYP_NDAC: route = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
			default: src_bad = 1'b1;
		endcase
	end

	always_comb begin
		pins = '0;
		mode_bad = 1'b0;
		case (pin_mode)
			apd_pkg::MODE_DIFF: pins = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
			apd_pkg::MODE_SE_PAIR: pins = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
			apd_pkg::MODE_SE_POS: pins = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
			apd_pkg::MODE_SE_NEG: pins = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
			apd_pkg::MODE_PD_POS: pins = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
			apd_pkg::MODE_PD_POS_SENSE: pins = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
			apd_pkg::MODE_PD_NEG: pins = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
			default: mode_bad = 1'b1;
		endcase
	end

	assign reserved_code = src_bad | mode_bad;
endmodule // apd_chan_decode

/* File: verilog/apd_config_decode.sv */
// Overview of operation
// - output 1 source field: off, DAC, bypass, mix, split either way; 11x reserved
// - output 2 has its own source field, same codes, bits 7:5
// - output 1 pin mode: differential, dual single-ended, positive only, negative only
// - pseudo-differential modes: positive signal, with remote sense, or negative signal
// - output 2 has an equivalent pin mode field in bits 4:2
// - each of the four output pins has its own two-bit drive setting
// - reference level codes: 2.75 V default, 2.5 V, 1.375 V; 11 reserved
// - per-channel full-scale bit set to 1 enables double-swing input mode
// - fast-charge duration: 3.5, 10, 50 or 100 ms, default 3.5 ms
// - reference off in sleep; fast-charges for programmed time after wake
// - bias code 00 follows reference, 11 follows supply, 10 reserved
// - bias code 01 gives half reference for reference codes 00 and 01
// - one register bit switches microphone bias power, off after reset
// - when pin control is enabled the pin, not the bit, powers the bias
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module apd_config_decode #(
	parameter int QCHG_CYC_0 = apd_pkg::QCHG_CYC_0, // 3.5 ms in cycles
	parameter int QCHG_CYC_1 = apd_pkg::QCHG_CYC_1, // 10 ms in cycles
	parameter int QCHG_CYC_2 = apd_pkg::QCHG_CYC_2, // 50 ms in cycles
	parameter int QCHG_CYC_3 = apd_pkg::QCHG_CYC_3 // 100 ms in cycles
) (
	input wire logic ref_clk, // 250 MHz control clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic [apd_pkg::ADDR_W-1:0] reg_addr, // register address
	input wire logic [apd_pkg::DATA_W-1:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [apd_pkg::DATA_W-1:0] reg_rdata, // read data, cycle after strobe
	input wire logic sleep_req, // device sleep level, same clock
	input wire logic general_pin_one, // asynchronous bias control pin
	output apd_pkg::apd_chan_type out_ch1, // channel 1 analog controls
	output apd_pkg::apd_chan_type out_ch2, // channel 2 analog controls
	output apd_pkg::apd_ref_type reference_ctrl, // reference block controls
	output apd_pkg::apd_bias_type mic_bias_ctrl // microphone bias controls
);
	localparam int CW = apd_pkg::QCHG_CNT_W;

	// the charge counter must hold the longest programmed duration
	if (QCHG_CYC_0 < 1 || QCHG_CYC_1 < 1 || QCHG_CYC_2 < 1 || QCHG_CYC_3 < 1) begin : g_bad_min
		$error("fast-charge counts must be at least one cycle");
	end
	if (QCHG_CYC_0 >= (1 << CW) || QCHG_CYC_1 >= (1 << CW) || QCHG_CYC_2 >= (1 << CW) ||
		QCHG_CYC_3 >= (1 << CW)) begin : g_bad_max
		$error("fast-charge counts exceed counter width");
	end

	// register fields
	logic [2:0] out_ch1_source_sel;
	logic [2:0] out_ch1_pin_mode;
	logic [2:0] out_ch2_source_sel;
	logic [2:0] out_ch2_pin_mode;
	logic [1:0] ch1_pos_pin_drive;
	logic [1:0] ch1_neg_pin_drive;
	logic [1:0] ch2_pos_pin_drive;
	logic [1:0] ch2_neg_pin_drive;
	logic [1:0] reference_level_sel;
	logic [1:0] reference_fast_charge_time;
	logic [1:0] mic_bias_level_sel;
	logic mic_bias_power_on;
	logic [1:0] double_swing_sel;
	logic bias_pin_ctrl_en;

	// decode results
	apd_pkg::apd_route_type route1;
	apd_pkg::apd_route_type route2;
	apd_pkg::apd_pin_type pins1;
	apd_pkg::apd_pin_type pins2;
	logic bad1;
	logic bad2;
	logic pin_level;
	logic bias_power_eff;
	logic level_bad;
	apd_pkg::apd_bias_type next_bias;
	logic [2:0] next_level;
	logic [apd_pkg::DATA_W-1:0] next_rdata;

	// reference sequencer
	apd_pkg::apd_ref_state_type ref_state;
	apd_pkg::apd_ref_state_type next_ref_state;
	logic [CW-1:0] charge_cnt;
	logic [CW-1:0] charge_load;

	logic wr_hit_ch1;
	logic wr_hit_ch2;
	logic wr_hit_drive;
	logic wr_hit_levels;
	logic wr_hit_charge;
	logic wr_hit_bias;
	logic wr_hit_misc;

	assign wr_hit_ch1 = reg_wr && (reg_addr == apd_pkg::ADDR_CH1_CFG);
	assign wr_hit_ch2 = reg_wr && (reg_addr == apd_pkg::ADDR_CH2_CFG);
	assign wr_hit_drive = reg_wr && (reg_addr == apd_pkg::ADDR_DRIVE);
	assign wr_hit_levels = reg_wr && (reg_addr == apd_pkg::ADDR_LEVELS);
	assign wr_hit_charge = reg_wr && (reg_addr == apd_pkg::ADDR_REF_CHARGE);
	assign wr_hit_bias = reg_wr && (reg_addr == apd_pkg::ADDR_BIAS_PWR);
	assign wr_hit_misc = reg_wr && (reg_addr == apd_pkg::ADDR_MISC);

	// channel configuration registers
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			out_ch1_source_sel <= apd_pkg::RST_REG[apd_pkg::SRC_MSB:apd_pkg::SRC_LSB];
			out_ch1_pin_mode <= apd_pkg::RST_REG[apd_pkg::MODE_MSB:apd_pkg::MODE_LSB];
		end else if (wr_hit_ch1) begin
			out_ch1_source_sel <= reg_wdata[apd_pkg::SRC_MSB:apd_pkg::SRC_LSB];
			out_ch1_pin_mode <= reg_wdata[apd_pkg::MODE_MSB:apd_pkg::MODE_LSB];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			out_ch2_source_sel <= apd_pkg::RST_REG[apd_pkg::SRC_MSB:apd_pkg::SRC_LSB];
			out_ch2_pin_mode <= apd_pkg::RST_REG[apd_pkg::MODE_MSB:apd_pkg::MODE_LSB];
		end else if (wr_hit_ch2) begin
			out_ch2_source_sel <= reg_wdata[apd_pkg::SRC_MSB:apd_pkg::SRC_LSB];
			out_ch2_pin_mode <= reg_wdata[apd_pkg::MODE_MSB:apd_pkg::MODE_LSB];
		end
	end

	// per-pin drive register
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ch1_pos_pin_drive <= apd_pkg::RST_REG[apd_pkg::DRV_C1P_MSB:apd_pkg::DRV_C1P_LSB];
			ch1_neg_pin_drive <= apd_pkg::RST_REG[apd_pkg::DRV_C1N_MSB:apd_pkg::DRV_C1N_LSB];
			ch2_pos_pin_drive <= apd_pkg::RST_REG[apd_pkg::DRV_C2P_MSB:apd_pkg::DRV_C2P_LSB];
			ch2_neg_pin_drive <= apd_pkg::RST_REG[apd_pkg::DRV_C2N_MSB:apd_pkg::DRV_C2N_LSB];
		end else if (wr_hit_drive) begin
			ch1_pos_pin_drive <= reg_wdata[apd_pkg::DRV_C1P_MSB:apd_pkg::DRV_C1P_LSB];
			ch1_neg_pin_drive <= reg_wdata[apd_pkg::DRV_C1N_MSB:apd_pkg::DRV_C1N_LSB];
			ch2_pos_pin_drive <= reg_wdata[apd_pkg::DRV_C2P_MSB:apd_pkg::DRV_C2P_LSB];
			ch2_neg_pin_drive <= reg_wdata[apd_pkg::DRV_C2N_MSB:apd_pkg::DRV_C2N_LSB];
		end
	end

	// reference and bias level register
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			reference_level_sel <= apd_pkg::RST_REG[apd_pkg::REF_MSB:apd_pkg::REF_LSB];
			mic_bias_level_sel <= apd_pkg::RST_REG[apd_pkg::BIAS_MSB:apd_pkg::BIAS_LSB];
		end else if (wr_hit_levels) begin
			reference_level_sel <= reg_wdata[apd_pkg::REF_MSB:apd_pkg::REF_LSB];
			mic_bias_level_sel <= reg_wdata[apd_pkg::BIAS_MSB:apd_pkg::BIAS_LSB];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			reference_fast_charge_time <= apd_pkg::RST_REG[apd_pkg::QCHG_MSB:apd_pkg::QCHG_LSB];
		end else if (wr_hit_charge) begin
			reference_fast_charge_time <= reg_wdata[apd_pkg::QCHG_MSB:apd_pkg::QCHG_LSB];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mic_bias_power_on <= apd_pkg::RST_REG[apd_pkg::BIAS_PWR_BIT];
		end else if (wr_hit_bias) begin
			mic_bias_power_on <= reg_wdata[apd_pkg::BIAS_PWR_BIT];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			double_swing_sel <= {apd_pkg::RST_REG[apd_pkg::MISC_SWING2_BIT], apd_pkg::RST_REG[apd_pkg::MISC_SWING1_BIT]};
			bias_pin_ctrl_en <= apd_pkg::RST_REG[apd_pkg::MISC_PIN_BIAS_BIT];
		end else if (wr_hit_misc) begin
			double_swing_sel <= {reg_wdata[apd_pkg::MISC_SWING2_BIT], reg_wdata[apd_pkg::MISC_SWING1_BIT]};
			bias_pin_ctrl_en <= reg_wdata[apd_pkg::MISC_PIN_BIAS_BIT];
		end
	end

	// both channels share one decoder design
	apd_chan_decode u_dec_ch1 (
		.source_sel(out_ch1_source_sel),
		.pin_mode(out_ch1_pin_mode),
		.route(route1),
		.pins(pins1),
		.reserved_code(bad1)
	);

	apd_chan_decode u_dec_ch2 (
		.source_sel(out_ch2_source_sel),
		.pin_mode(out_ch2_pin_mode),
		.route(route2),
		.pins(pins2),
		.reserved_code(bad2)
	);

	apd_pin_sync u_pin_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.pin_in(general_pin_one),
		.level(pin_level)
	);

	// pin overrides the register bit once handed control
	assign bias_power_eff = bias_pin_ctrl_en ? pin_level : mic_bias_power_on;

	// channel outputs; a reserved code parks the route and pins, drive and swing still pass
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			out_ch1 <= '0;
		end else begin
			out_ch1.route <= bad1 ? '0 : route1;
			out_ch1.pins <= bad1 ? '0 : pins1;
			out_ch1.pos_drive <= ch1_pos_pin_drive;
			out_ch1.neg_drive <= ch1_neg_pin_drive;
			out_ch1.double_swing <= double_swing_sel[0];
			out_ch1.reserved_code <= bad1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			out_ch2 <= '0;
		end else begin
			out_ch2.route <= bad2 ? '0 : route2;
			out_ch2.pins <= bad2 ? '0 : pins2;
			out_ch2.pos_drive <= ch2_pos_pin_drive;
			out_ch2.neg_drive <= ch2_neg_pin_drive;
			out_ch2.double_swing <= double_swing_sel[1];
			out_ch2.reserved_code <= bad2;
		end
	end

	// reference level decode
	always_comb begin
		next_level = 3'h0;
		level_bad = 1'b0;
		case (reference_level_sel)
			apd_pkg::REF_2V75: next_level = 3'h1;
			apd_pkg::REF_2V5: next_level = 3'h2;
			apd_pkg::REF_1V375: next_level = 3'h4;
			default: level_bad = 1'b1;
		endcase
	end

	// microphone bias level decode
	always_comb begin
		next_bias = '0;
		case (mic_bias_level_sel)
			apd_pkg::BIAS_AS_REF: next_bias.from_ref = !level_bad;
			apd_pkg::BIAS_HALF_REF: next_bias.half_ref = (reference_level_sel == apd_pkg::REF_2V75) ||
				(reference_level_sel == apd_pkg::REF_2V5);
			apd_pkg::BIAS_SUPPLY: next_bias.from_supply = 1'b1;
			default: next_bias = '0;
		endcase
		next_bias.power_on = bias_power_eff && (next_bias.from_ref || next_bias.half_ref || next_bias.from_supply);
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mic_bias_ctrl <= '0;
		end else begin
			mic_bias_ctrl <= next_bias;
		end
	end

	// duration is sampled when charging starts; later writes apply next wake
	always_comb begin
		case (reference_fast_charge_time)
			2'h0: charge_load = CW'(QCHG_CYC_0 - 1);
			2'h1: charge_load = CW'(QCHG_CYC_1 - 1);
			2'h2: charge_load = CW'(QCHG_CYC_2 - 1);
			default: charge_load = CW'(QCHG_CYC_3 - 1);
		endcase
	end

	always_comb begin
		next_ref_state = ref_state;
		case (ref_state)
			apd_pkg::REF_ST_OFF: begin
				if (!sleep_req) begin
					next_ref_state = apd_pkg::REF_ST_CHARGE;
				end
			end
			apd_pkg::REF_ST_CHARGE: begin
				if (sleep_req) begin
					next_ref_state = apd_pkg::REF_ST_OFF;
				end else if (charge_cnt == '0) begin
					next_ref_state = apd_pkg::REF_ST_SETTLED;
				end
			end
			apd_pkg::REF_ST_SETTLED: begin
				if (sleep_req) begin
					next_ref_state = apd_pkg::REF_ST_OFF;
				end
			end
			default: next_ref_state = apd_pkg::REF_ST_OFF;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ref_state <= apd_pkg::REF_ST_OFF;
		end else begin
			ref_state <= next_ref_state;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			charge_cnt <= '0;
		end else if (ref_state == apd_pkg::REF_ST_OFF) begin
			charge_cnt <= charge_load;
		end else if (ref_state == apd_pkg::REF_ST_CHARGE && charge_cnt != '0) begin
			charge_cnt <= charge_cnt - CW'(1);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			reference_ctrl <= '0;
		end else begin
			reference_ctrl.level_onehot <= next_level;
			reference_ctrl.power_on <= next_ref_state != apd_pkg::REF_ST_OFF;
			reference_ctrl.fast_charge <= next_ref_state == apd_pkg::REF_ST_CHARGE;
			reference_ctrl.settled <= next_ref_state == apd_pkg::REF_ST_SETTLED;
		end
	end

	// read mux; unmapped addresses and undefined bits read zero
	always_comb begin
		next_rdata = '0;
		case (reg_addr)
			apd_pkg::ADDR_CH1_CFG: begin
				next_rdata[apd_pkg::SRC_MSB:apd_pkg::SRC_LSB] = out_ch1_source_sel;
				next_rdata[apd_pkg::MODE_MSB:apd_pkg::MODE_LSB] = out_ch1_pin_mode;
			end
			apd_pkg::ADDR_CH2_CFG: begin
				next_rdata[apd_pkg::SRC_MSB:apd_pkg::SRC_LSB] = out_ch2_source_sel;
				next_rdata[apd_pkg::MODE_MSB:apd_pkg::MODE_LSB] = out_ch2_pin_mode;
			end
			apd_pkg::ADDR_DRIVE: begin
				next_rdata = {ch1_pos_pin_drive, ch1_neg_pin_drive, ch2_pos_pin_drive, ch2_neg_pin_drive};
			end
			apd_pkg::ADDR_LEVELS: begin
				next_rdata[apd_pkg::BIAS_MSB:apd_pkg::BIAS_LSB] = mic_bias_level_sel;
				next_rdata[apd_pkg::REF_MSB:apd_pkg::REF_LSB] = reference_level_sel;
			end
			apd_pkg::ADDR_REF_CHARGE: begin
				next_rdata[apd_pkg::QCHG_MSB:apd_pkg::QCHG_LSB] = reference_fast_charge_time;
			end
			apd_pkg::ADDR_BIAS_PWR: begin
				next_rdata[apd_pkg::BIAS_PWR_BIT] = mic_bias_power_on;
			end
			apd_pkg::ADDR_MISC: begin
				next_rdata[apd_pkg::MISC_SWING1_BIT] = double_swing_sel[0];
				next_rdata[apd_pkg::MISC_SWING2_BIT] = double_swing_sel[1];
				next_rdata[apd_pkg::MISC_PIN_BIAS_BIT] = bias_pin_ctrl_en;
			end
			apd_pkg::ADDR_STATUS: begin
				next_rdata = {1'b0, pin_level, bias_power_eff, level_bad, bad2, bad1,
					ref_state == apd_pkg::REF_ST_CHARGE, ref_state == apd_pkg::REF_ST_SETTLED};
			end
			default: next_rdata = '0;
		endcase
	end

	// read data holds for exactly one cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= '0;
		end
	end
endmodule // apd_config_decode

/* File: verilog/apd_pin_sync.sv */
`timescale 1ns/1ps
module apd_pin_sync (
	input wire logic ref_clk, // clock
	input wire logic rst_n, // sync reset, active low
	input wire logic pin_in, // asynchronous pin
	output logic level // filtered level
);
	logic stage1;
	logic stage2;
	logic stage3;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
		end else begin
			stage1 <= pin_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// change accepted only once the last two stages agree
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			level <= 1'b0;
		end else if (stage2 == stage3) begin
			level <= stage3;
		end
	end
endmodule // apd_pin_sync
